// ---- core/ckl_cfg.svh ----
// Offsets, field positions, reset values and counts for the carrier keying logic
`ifndef CKL_CFG_SVH
`define CKL_CFG_SVH

// ==========================================
// Register offsets (byte addresses)
`define CKL_OFS_W          8
`define CKL_OFS_CONFIG     8'h00
`define CKL_OFS_STATUS     8'h04

// ==========================================
// Configuration register fields
`define CKL_CFG_W          13
`define CKL_CFG_RESET      13'h0000
`define CKL_CFG_POL        0
`define CKL_CFG_SCHEME     1
`define CKL_CFG_PLAN       2
`define CKL_CFG_TONES      3
`define CKL_CFG_UP_EN      4
`define CKL_CFG_LO_EN      5
`define CKL_CFG_UP_REST    6
`define CKL_CFG_LO_REST    7
`define CKL_CFG_TRIP_EN    8
`define CKL_CFG_TALK_EN    9
`define CKL_CFG_BOOST_EN   10
`define CKL_CFG_OFF_EN     11
`define CKL_CFG_UNBLK_EN   12

// ==========================================
// Synchronised input vector positions
`define CKL_IN_W           9
`define CKL_IN_TRIP        0
`define CKL_IN_BOOST       1
`define CKL_IN_OFF         2
`define CKL_IN_UNBLK       3
`define CKL_IN_EXT_TALK    4
`define CKL_IN_INT_TALK    5
`define CKL_IN_BTN_LEVEL   6
`define CKL_IN_BTN_UP      7
`define CKL_IN_BTN_LO      8

// ==========================================
// Status register layout, timing counts and bus transfer encoding
`define CKL_STAT_IN_POS    8
`define CKL_SYNC_STAGES    2
`define CKL_HTRANS_NONSEQ  2'h2

`endif

// ---- core/ckl_keying.sv ----
// Carrier keying logic top level with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module ckl_keying
  import ckl_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // Isolated keying inputs, active high when energised
  input  wire logic              directTransferTripKey,
  input  wire logic              breakerAuxPowerBoost,
  input  wire logic              powerOffKey,
  input  wire logic              unblockKey,
  input  wire logic              extTalkKey,
  input  wire logic              intTalkKey,
  // Front panel buttons, active high while pressed
  input  wire logic              highLevelTestButton,
  input  wire logic              upperShiftTestButton,
  input  wire logic              lowerShiftTestButton,
  // Keying commands to the transmitter
  output logic                   highLevelOut,
  output logic                   upperShiftOut,
  output logic                   lowerShiftOut,
  output logic                   talkKeyOut,
  output logic                   transmitKeyOut,
  output logic                   upperContactOut,
  output logic                   lowerContactOut,
  output logic                   highPowerLevel
);

  // ==========================================
  // Functions

  // Contact drive: off when disabled, else shift or its complement
  // An enabled closed-at-rest contact reads closed whenever its shift is idle
  // Disabled contacts stay open in either rest setting
  function automatic logic contactDrive(
    input logic enable,
    input logic closedAtRest,
    input logic shift
  );
    contactDrive = enable & (shift ^ closedAtRest);
  endfunction

  // Read multiplexer; unmapped offsets read as zero
  function automatic logic [31:0] regRead(
    input logic [`CKL_OFS_W-1:0] offset,
    input logic [`CKL_CFG_W-1:0] cfgBits,
    input logic [7:0]            outBits,
    input logic [`CKL_IN_W-1:0]  inBits
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    case (offset)
      `CKL_OFS_CONFIG: begin
        word[`CKL_CFG_W-1:0] = cfgBits;
      end
      `CKL_OFS_STATUS: begin
        word[7:0] = outBits;
        word[`CKL_STAT_IN_POS +: `CKL_IN_W] = inBits;
      end
      default: begin
        word = 32'h0000_0000;
      end
    endcase
    regRead = word;
  endfunction

  // ==========================================
  // State and synchronised inputs

  ckl_state_t             s;
  ckl_state_t             next_s;
  logic [`CKL_IN_W-1:0]   rawIn;
  logic [`CKL_IN_W-1:0]   syncIn;

  // Gather pins in vector order
  always_comb begin
    rawIn                    = '0;
    rawIn[`CKL_IN_TRIP]      = directTransferTripKey;
    rawIn[`CKL_IN_BOOST]     = breakerAuxPowerBoost;
    rawIn[`CKL_IN_OFF]       = powerOffKey;
    rawIn[`CKL_IN_UNBLK]     = unblockKey;
    rawIn[`CKL_IN_EXT_TALK]  = extTalkKey;
    rawIn[`CKL_IN_INT_TALK]  = intTalkKey;
    rawIn[`CKL_IN_BTN_LEVEL] = highLevelTestButton;
    rawIn[`CKL_IN_BTN_UP]    = upperShiftTestButton;
    rawIn[`CKL_IN_BTN_LO]    = lowerShiftTestButton;
  end

  // Two flip-flops on every pin before any decode
  ckl_sync #(
    .WIDTH (`CKL_IN_W)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (rawIn),
    .dout  (syncIn)
  );

  // ==========================================
  // Qualified requests

  logic tripReq;
  logic boostReq;
  logic unblockReq;
  logic extTalkReq;
  logic intTalkReq;
  logic phaseScheme;
  logic threeTone;
  logic reversedPolarity;
  logic bothHighPlan;

  // Each request needs its enable bit and an energised input
  // Internal talk has no enable: the adapter is either fitted or absent
  assign tripReq    = s.cfgBits[`CKL_CFG_TRIP_EN] & syncIn[`CKL_IN_TRIP];
  assign boostReq   = s.cfgBits[`CKL_CFG_BOOST_EN] & syncIn[`CKL_IN_BOOST];
  assign unblockReq = s.cfgBits[`CKL_CFG_UNBLK_EN] & syncIn[`CKL_IN_UNBLK];
  assign extTalkReq = s.cfgBits[`CKL_CFG_TALK_EN] & syncIn[`CKL_IN_EXT_TALK];
  assign intTalkReq = syncIn[`CKL_IN_INT_TALK];

  // Mode bits
  // Contact enables are not cleared in a phase scheme; the installer owns
  // that choice, so contacts left enabled keep following their shifts
  assign phaseScheme      = s.cfgBits[`CKL_CFG_SCHEME];
  assign threeTone        = s.cfgBits[`CKL_CFG_TONES];
  assign reversedPolarity = s.cfgBits[`CKL_CFG_POL];
  assign bothHighPlan     = s.cfgBits[`CKL_CFG_PLAN];

  // ==========================================
  // Shift and level decode from relay requests

  logic keyLower;
  logic keyUpper;
  logic keyLevel;
  logic talkWithTrip;
  logic normLevel;

  // Lower shift on trip or unblock in two-tone, on trip only in three-tone
  assign keyLower = threeTone ? tripReq : (tripReq | unblockReq);

  // Two-tone upper is the complement; three-tone upper on unblock alone
  assign keyUpper = threeTone ? (unblockReq & ~tripReq) : ~keyLower;

  // Trip-driven lower shift raises level; phase keying does not
  assign keyLevel = threeTone ? tripReq
                              : (tripReq | (unblockReq & ~phaseScheme));

  // External talk keyed over a trip holds the level down
  // This suppression wins over a power boost as well
  assign talkWithTrip = extTalkReq & tripReq;
  assign normLevel    = (boostReq | keyLevel) & ~talkWithTrip;

  // ==========================================
  // Test buttons override the relay decode

  logic btnLevel;
  logic btnUpper;
  logic btnLower;
  logic shiftUp;
  logic shiftDown;
  logic levelKey;

  assign btnLevel = syncIn[`CKL_IN_BTN_LEVEL];
  assign btnUpper = syncIn[`CKL_IN_BTN_UP];
  assign btnLower = syncIn[`CKL_IN_BTN_LO];

  // Upper button first, then lower, then high level button
  // Buttons touch only shifts and level; talk and transmit keys still follow
  // their inputs so a test never drops a voice or power-off key
  always_comb begin
    if (btnUpper) begin
      shiftUp   = 1'b1;
      shiftDown = 1'b0;
      levelKey  = 1'b0;
    end else if (btnLower) begin
      shiftUp   = 1'b0;
      shiftDown = 1'b1;
      levelKey  = 1'b0;
    end else if (btnLevel) begin
      shiftUp   = 1'b1;
      shiftDown = 1'b0;
      levelKey  = 1'b1;
    end else begin
      shiftUp   = keyUpper;
      shiftDown = keyLower;
      levelKey  = normLevel;
    end
  end

  // ==========================================
  // Bus decode

  logic                  addrPhase;
  logic                  busWrite;
  logic                  busRead;
  logic [`CKL_OFS_W-1:0] busOffset;
  logic [7:0]            outBits;

  // Transfer taken when selected, ready and non-idle
  // A read whose address phase meets a write's data phase sees the old
  // configuration, because the write lands only at the end of its data phase
  assign addrPhase = hsel & hready & htrans[1];
  assign busWrite  = addrPhase & hwrite;
  assign busRead   = addrPhase & ~hwrite;
  assign busOffset = haddr[`CKL_OFS_W-1:0];

  // Output flags as seen in the status register
  assign outBits = {s.highPowerLevel, s.lowerContactOut, s.upperContactOut,
                    s.transmitKeyOut, s.talkKeyOut, s.lowerShiftOut,
                    s.upperShiftOut, s.highLevelOut};

  // ==========================================
  // Next state

  always_comb begin
    next_s = s;

    // Write data phase lands in the configuration register
    case (s.busPhase)
      CKL_BUS_IDLE: begin
        next_s.busPhase = CKL_BUS_IDLE;
      end
      CKL_BUS_WRITE: begin
        if (s.wrOffset == `CKL_OFS_CONFIG) begin
          next_s.cfgBits = hwdata[`CKL_CFG_W-1:0];
        end
        next_s.busPhase = CKL_BUS_IDLE;
      end
      default: begin
        next_s.busPhase = CKL_BUS_IDLE;
      end
    endcase

    // New address phase; read data is ready for the data phase
    if (busWrite) begin
      next_s.busPhase = CKL_BUS_WRITE;
      next_s.wrOffset = busOffset;
    end
    if (busRead) begin
      next_s.readData = regRead(busOffset, s.cfgBits, outBits, syncIn);
    end

    // Keying commands, one edge after the synchroniser output
    // Pin to output latency is three edges in all
    next_s.upperShiftOut  = shiftUp;
    next_s.lowerShiftOut  = shiftDown;
    next_s.highLevelOut   = levelKey;
    next_s.highPowerLevel = levelKey | bothHighPlan;
    next_s.talkKeyOut     = intTalkReq | (extTalkReq & ~boostReq);

    // Power-off input keys the transmitter in either polarity
    next_s.transmitKeyOut = s.cfgBits[`CKL_CFG_OFF_EN]
                          & (syncIn[`CKL_IN_OFF] ^ reversedPolarity);

    // Contacts gated by enable, inverted when closed at rest
    next_s.upperContactOut = contactDrive(s.cfgBits[`CKL_CFG_UP_EN],
                                          s.cfgBits[`CKL_CFG_UP_REST],
                                          shiftUp);
    next_s.lowerContactOut = contactDrive(s.cfgBits[`CKL_CFG_LO_EN],
                                          s.cfgBits[`CKL_CFG_LO_REST],
                                          shiftDown);
  end

  // ==========================================
  // State register, synchronous active-low reset
  // The synchroniser clears as well, so no stale pin key survives release

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s.busPhase        <= CKL_BUS_IDLE;
      s.wrOffset        <= '0;
      s.cfgBits         <= `CKL_CFG_RESET;
      s.readData        <= 32'h0000_0000;
      s.highLevelOut    <= 1'b0;
      s.upperShiftOut   <= 1'b0;
      s.lowerShiftOut   <= 1'b0;
      s.talkKeyOut      <= 1'b0;
      s.transmitKeyOut  <= 1'b0;
      s.upperContactOut <= 1'b0;
      s.lowerContactOut <= 1'b0;
      s.highPowerLevel  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs

  // Zero wait states, always OKAY
  // Nothing in this slave can stall, so hreadyout is a constant
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.readData;

  // Keying commands straight from flip-flops
  assign highLevelOut    = s.highLevelOut;
  assign upperShiftOut   = s.upperShiftOut;
  assign lowerShiftOut   = s.lowerShiftOut;
  assign talkKeyOut      = s.talkKeyOut;
  assign transmitKeyOut  = s.transmitKeyOut;
  assign upperContactOut = s.upperContactOut;
  assign lowerContactOut = s.lowerContactOut;
  assign highPowerLevel  = s.highPowerLevel;

endmodule
`default_nettype wire

// ---- core/ckl_pkg.sv ----
// Types shared by the carrier keying logic
`include "ckl_cfg.svh"

package ckl_pkg;

  // ==========================================
  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    CKL_BUS_IDLE  = 2'b01,
    CKL_BUS_WRITE = 2'b10
  } ckl_bus_t;

  // ==========================================
  // Whole state of the keying top level
  typedef struct packed {
    ckl_bus_t                 busPhase;
    logic [`CKL_OFS_W-1:0]    wrOffset;
    logic [`CKL_CFG_W-1:0]    cfgBits;
    logic [31:0]              readData;
    logic                     highLevelOut;
    logic                     upperShiftOut;
    logic                     lowerShiftOut;
    logic                     talkKeyOut;
    logic                     transmitKeyOut;
    logic                     upperContactOut;
    logic                     lowerContactOut;
    logic                     highPowerLevel;
  } ckl_state_t;

endpackage

// ---- core/ckl_sync.sv ----
// Multi-bit two-stage input synchroniser
`timescale 1ns/1ps
`default_nettype none

module ckl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ckl_sync_state_t;

  ckl_sync_state_t s;
  ckl_sync_state_t next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s        = s;
    next_s.stage1 = din;
    next_s.stage2 = s.stage1;
  end

  // Synchronous clear to zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stage2;

endmodule
`default_nettype wire

// ---- tb/ckl_keying_asserts.sv ----
// Port-level assertions for the carrier keying top level
`timescale 1ns/1ps
`default_nettype none
`include "ckl_cfg.svh"

// ==========================================
// Checker
module ckl_keying_asserts
  import ckl_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic              directTransferTripKey,
  input wire logic              breakerAuxPowerBoost,
  input wire logic              powerOffKey,
  input wire logic              unblockKey,
  input wire logic              extTalkKey,
  input wire logic              intTalkKey,
  input wire logic              highLevelTestButton,
  input wire logic              upperShiftTestButton,
  input wire logic              lowerShiftTestButton,
  input wire logic              highLevelOut,
  input wire logic              upperShiftOut,
  input wire logic              lowerShiftOut,
  input wire logic              talkKeyOut,
  input wire logic              transmitKeyOut,
  input wire logic              upperContactOut,
  input wire logic              lowerContactOut,
  input wire logic              highPowerLevel
);
  logic [8:0]  pin;
  logic [8:0]  p1, p2, p3;
  logic [12:0] cfgM, cfgP;
  logic        wrPend;
  logic [2:0]  age;
  logic        tr, ub, bo, ex, btn;

  // Pins packed in synchroniser order
  assign pin = {lowerShiftTestButton, upperShiftTestButton, highLevelTestButton, intTalkKey,
                extTalkKey, unblockKey, powerOffKey, breakerAuxPowerBoost, directTransferTripKey};

  // Mirror of the configuration word and time since reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      cfgM   <= 13'h0000;
      age    <= 3'h0;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == `CKL_OFS_CONFIG;
      if (wrPend) cfgM <= hwdata[`CKL_CFG_W-1:0];
      if (age != 3'h4) age <= age + 3'h1;
    end
  end

  // Pins and config aligned with the three-edge output latency
  always_ff @(posedge clk) begin
    p1   <= pin;
    p2   <= p1;
    p3   <= p2;
    cfgP <= cfgM;
  end

  // Requests that pass their enable bits
  assign tr  = p3[`CKL_IN_TRIP] & cfgP[`CKL_CFG_TRIP_EN];
  assign ub  = p3[`CKL_IN_UNBLK] & cfgP[`CKL_CFG_UNBLK_EN];
  assign bo  = p3[`CKL_IN_BOOST] & cfgP[`CKL_CFG_BOOST_EN];
  assign ex  = p3[`CKL_IN_EXT_TALK] & cfgP[`CKL_CFG_TALK_EN];
  assign btn = |p3[8:6];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence settled_s; age == 3'h4; endsequence
  sequence quiet_s; settled_s ##0 !btn; endsequence

  trip_low_a: assert property (
    quiet_s ##0 tr |-> lowerShiftOut && !upperShiftOut)
    else $error("trip request did not shift low");
  no_key_a: assert property (quiet_s ##0 !tr && !ub |-> !lowerShiftOut)
    else $error("shift low without a key request");
  two_tone_a: assert property (
    settled_s ##0 !cfgP[`CKL_CFG_TONES] |-> upperShiftOut != lowerShiftOut)
    else $error("shifts not complementary in two-tone");
  three_unblock_a: assert property (
    quiet_s ##0 cfgP[`CKL_CFG_TONES] && ub && !tr && !bo
    |-> upperShiftOut && !lowerShiftOut && !highLevelOut)
    else $error("three-tone unblock mapped wrongly");
  scheme_level_a: assert property (
    quiet_s ##0 !cfgP[`CKL_CFG_TONES] && ub && !tr && !bo
    |-> highLevelOut == !cfgP[`CKL_CFG_SCHEME])
    else $error("unblock level wrong for scheme");
  boost_level_a: assert property (
    quiet_s ##0 (bo || tr) && !(ex && tr) |-> highLevelOut)
    else $error("high level missing");
  talk_trip_a: assert property (quiet_s ##0 ex && tr |-> !highLevelOut)
    else $error("high level with talk and trip");
  talk_key_a: assert property (
    settled_s |-> talkKeyOut == (p3[`CKL_IN_INT_TALK] || (ex && !bo)))
    else $error("talk key wrong");
  transmit_a: assert property (
    settled_s
    |-> transmitKeyOut == (cfgP[`CKL_CFG_OFF_EN] && (p3[`CKL_IN_OFF] ^ cfgP[`CKL_CFG_POL])))
    else $error("transmit key wrong");
  power_plan_a: assert property (
    settled_s |-> highPowerLevel == (highLevelOut || cfgP[`CKL_CFG_PLAN]))
    else $error("power level wrong");
  upper_contact_a: assert property (
    settled_s |-> upperContactOut
    == (cfgP[`CKL_CFG_UP_EN] && (upperShiftOut ^ cfgP[`CKL_CFG_UP_REST])))
    else $error("upper contact wrong");
  lower_contact_a: assert property (
    settled_s |-> lowerContactOut
    == (cfgP[`CKL_CFG_LO_EN] && (lowerShiftOut ^ cfgP[`CKL_CFG_LO_REST])))
    else $error("lower contact wrong");
  upper_button_a: assert property (
    settled_s ##0 p3[`CKL_IN_BTN_UP]
    |-> upperShiftOut && !lowerShiftOut && !highLevelOut)
    else $error("upper button ignored");
  lower_button_a: assert property (
    settled_s ##0 p3[8:7] == 2'b10 |-> lowerShiftOut && !upperShiftOut)
    else $error("lower button ignored");
  level_button_a: assert property (
    settled_s ##0 p3[8:6] == 3'b001 |-> highLevelOut && upperShiftOut)
    else $error("level button ignored");
  reset_out_a: assert property ($rose(rst_b)
    |-> !highLevelOut && !upperShiftOut && !lowerShiftOut && !talkKeyOut
    && !transmitKeyOut && !upperContactOut && !lowerContactOut && !highPowerLevel)
    else $error("output active in reset");
endmodule

bind ckl_keying ckl_keying_asserts #(.ADDR_W(ADDR_W)) ckl_keying_asserts_i (.*);
`default_nettype wire

// ---- tb/ckl_relay_model.sv ----
// Behavioural relay system driving the isolated keying inputs
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Relay model
module ckl_relay_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [5:0] cmd,
  output logic      [5:0] keys
);
  logic [5:0] held;

  // Slow contacts settle one cycle late
  always_ff @(posedge clk) begin
    held <= cmd;
  end

  assign keys = slow ? held : cmd;
endmodule
`default_nettype wire

// ---- tb/test_ckl_keying.sv ----
// Self-checking bench for the carrier keying logic
`timescale 1ns/1ps
`default_nettype none
`include "ckl_cfg.svh"

// ==========================================
// Bench top
module test_ckl_keying
  import ckl_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [8:0]  pv = 9'h000;
  logic        slow = 1'b0;
  logic [31:0] rd, rc;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  wire  [5:0]  keys;
  wire  [7:0]  outs;
  logic [21:0] rows [15] = '{{13'h1f30, 9'h000}, {13'h1f30, 9'h008}, {13'h1f26, 9'h020},
    {13'h1f16, 9'h001}, {13'h1ffa, 9'h001}, {13'h1ffa, 9'h008}, {13'h1f32, 9'h015},
    {13'h1f33, 9'h012}, {13'h1f33, 9'h006}, {13'h1f32, 9'h100}, {13'h1f32, 9'h089},
    {13'h1f32, 9'h040}, {13'h0030, 9'h03f}, {13'h1f02, 9'h008}, {13'h1f0a, 9'h01b}};

  always #4 clk = ~clk;

  ckl_relay_model ckl_relay_model_i (.clk(clk), .slow(slow), .cmd(pv[5:0]), .keys(keys));

  ckl_keying ckl_keying_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .directTransferTripKey(keys[0]), .breakerAuxPowerBoost(keys[1]), .powerOffKey(keys[2]),
    .unblockKey(keys[3]), .extTalkKey(keys[4]), .intTalkKey(keys[5]),
    .highLevelTestButton(pv[6]), .upperShiftTestButton(pv[7]), .lowerShiftTestButton(pv[8]),
    .highLevelOut(outs[0]), .upperShiftOut(outs[1]), .lowerShiftOut(outs[2]),
    .talkKeyOut(outs[3]), .transmitKeyOut(outs[4]), .upperContactOut(outs[5]),
    .lowerContactOut(outs[6]), .highPowerLevel(outs[7]));

  // Expected keying outputs, status bit order
  function automatic logic [7:0] expect_out(input logic [12:0] c, input logic [8:0] p);
    logic tr, ub, bo, ex, lk, lo, up, hl;
    tr = c[`CKL_CFG_TRIP_EN] & p[`CKL_IN_TRIP];
    ub = c[`CKL_CFG_UNBLK_EN] & p[`CKL_IN_UNBLK];
    bo = c[`CKL_CFG_BOOST_EN] & p[`CKL_IN_BOOST];
    ex = c[`CKL_CFG_TALK_EN] & p[`CKL_IN_EXT_TALK];
    lo = c[`CKL_CFG_TONES] ? tr : tr | ub;
    up = c[`CKL_CFG_TONES] ? ub & ~tr : ~lo;
    lk = tr | (ub & ~c[`CKL_CFG_TONES] & ~c[`CKL_CFG_SCHEME]);
    hl = (bo | lk) & ~(ex & tr);
    if (p[`CKL_IN_BTN_UP]) {up, lo, hl} = 3'b100;
    else if (p[`CKL_IN_BTN_LO]) {up, lo, hl} = 3'b010;
    else if (p[`CKL_IN_BTN_LEVEL]) {up, lo, hl} = 3'b101;
    return {hl | c[`CKL_CFG_PLAN], c[`CKL_CFG_LO_EN] & (lo ^ c[`CKL_CFG_LO_REST]),
            c[`CKL_CFG_UP_EN] & (up ^ c[`CKL_CFG_UP_REST]),
            c[`CKL_CFG_OFF_EN] & (p[`CKL_IN_OFF] ^ c[`CKL_CFG_POL]),
            p[`CKL_IN_INT_TALK] | (ex & ~bo), lo, up, hl};
  endfunction

  // Compare tasks for output bytes and bus words
  task automatic chk_out(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] got);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ofs};
    htrans <= `CKL_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    got = hrdata;
    chk_out("response", 8'h00, {7'h0, hresp});
  endtask

  // Configure, key the pins, then check outputs and status
  task automatic run_case(input logic [12:0] c, input logic [8:0] p);
    logic [7:0] e;
    e = expect_out(c, p);
    ahb(1'b1, `CKL_OFS_CONFIG, {19'h0, c}, rd);
    @(posedge clk);
    pv <= p;
    repeat (3 + slow) @(posedge clk);
    #1;
    chk_out("upper shift", {7'h0, e[1]}, {7'h0, outs[1]});
    chk_out("lower shift", {7'h0, e[2]}, {7'h0, outs[2]});
    chk_out("level", {6'h0, e[7], e[0]}, {6'h0, outs[7], outs[0]});
    chk_out("keys", {6'h0, e[4:3]}, {6'h0, outs[4:3]});
    chk_out("contacts", {6'h0, e[6:5]}, {6'h0, outs[6:5]});
    ahb(1'b0, `CKL_OFS_STATUS, 32'h0, rd);
    chk_word("status", {15'h0, p, e}, rd);
  endtask

  // Closing report
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cycle ceiling against a hung bench
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(33));
    repeat (16) @(posedge clk);
    #1;
    chk_out("reset outputs", 8'h00, outs);
    @(posedge clk);
    rst_b <= 1'b1;
    ahb(1'b0, `CKL_OFS_CONFIG, 32'h0, rd);
    chk_word("config reset", 32'h0, rd);
    ahb(1'b1, 8'h08, 32'hffffffff, rd);
    ahb(1'b1, `CKL_OFS_STATUS, 32'hffffffff, rd);
    ahb(1'b0, 8'h08, 32'h0, rd);
    chk_word("unmapped", 32'h0, rd);
    ahb(1'b0, `CKL_OFS_CONFIG, 32'h0, rd);
    chk_word("config kept", 32'h0, rd);
    $display("test registers done");
    // Table rows; two phase scheme rows have both contact enables out
    foreach (rows[i]) run_case(rows[i][21:9], rows[i][8:0]);
    $display("test table done");
    slow <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      rc = $urandom;
      run_case(rc[12:0], {rc[31:29] & {3{rc[28]}}, rc[21:16]});
    end
    $display("test random done");
    test_done();
  end
endmodule
`default_nettype wire
